//--- ppims_pkg.sv
// constants, register map, field layout and decode helpers for the per-port
// phy event, crossover and status register group.
// assumes an 18-bit apb byte address: port number in bits 17:14, word index below.
package ppims_pkg;

    // ========================================================
    // sizes
    localparam int NUM_PORTS   = 5;
    localparam int EVT_W       = 8;
    localparam int ADDR_W      = 18;
    localparam int SY_PER_PORT = 12;
    localparam int SYNC_W      = NUM_PORTS * SY_PER_PORT;

    // ========================================================
    // register indices within a port (byte address = index * 4)
    localparam logic [11:0] OFF_RXER  = 12'h12A;
    localparam logic [11:0] OFF_EVT   = 12'h136;
    localparam logic [11:0] OFF_XOVER = 12'h138;
    localparam logic [11:0] OFF_CTRL  = 12'h13E;
    localparam logic [11:0] OFF_GSTAT = 12'h010;
    localparam logic [11:0] OFF_GMASK = 12'h011;
    localparam logic [3:0]  PORT_GLOBAL = 4'h0;
    localparam logic [3:0]  PORT_FIRST  = 4'h1;
    localparam logic [3:0]  PORT_LAST   = 4'h5;

    // ========================================================
    // field positions
    localparam int EVT_EN_LSB      = 8;
    localparam int EVT_FLAG_LSB    = 0;
    localparam int EV_JABBER       = 7;
    localparam int EV_RX_ERR       = 6;
    localparam int EV_PAGE_RX      = 5;
    localparam int EV_PAR_FAULT    = 4;
    localparam int EV_LP_ACK       = 3;
    localparam int EV_LINK_DOWN    = 2;
    localparam int EV_REM_FAULT    = 1;
    localparam int EV_LINK_UP      = 0;
    localparam int XOVER_MDI_BIT   = 7;
    localparam int XOVER_AUTO_OFF  = 6;
    localparam int CTRL_JAB_BIT    = 9;
    localparam int CTRL_SP100_BIT  = 5;
    localparam int CTRL_SP10_BIT   = 4;
    localparam int CTRL_DUP_BIT    = 3;
    localparam int SY_SYMERR       = 8;
    localparam int SY_DUP          = 9;
    localparam int SY_SP10         = 10;
    localparam int SY_SP100        = 11;

    // ========================================================
    // reset values and masks
    localparam logic [15:0] EVT_RST    = 16'h0000;
    localparam logic [15:0] XOVER_RST  = 16'h0000;
    localparam logic [15:0] CTRL_RST   = 16'h0300;
    localparam logic [15:0] CTRL_WMASK = 16'hF380;
    localparam logic [15:0] EN_WMASK   = 16'hFF00;
    localparam logic [15:0] ALL_WMASK  = 16'hFFFF;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] CNT_RST    = 16'h0000;

    typedef enum logic [2:0] {
        RK_NONE, RK_EVT, RK_XOVER, RK_CTRL, RK_RXER, RK_GSTAT, RK_GMASK
    } ppims_reg_t;

    // ========================================================
    // helpers
    function automatic ppims_reg_t ppims_decode(input logic [ADDR_W-1:0] a);
        logic [3:0]  port;
        logic [11:0] off;
        port = a[17:14];
        off  = a[13:2];
        ppims_decode = RK_NONE;
        if (port == PORT_GLOBAL) begin
            if (off == OFF_GSTAT) ppims_decode = RK_GSTAT;
            if (off == OFF_GMASK) ppims_decode = RK_GMASK;
        end else if (port >= PORT_FIRST && port <= PORT_LAST) begin
            if (off == OFF_EVT)   ppims_decode = RK_EVT;
            if (off == OFF_XOVER) ppims_decode = RK_XOVER;
            if (off == OFF_CTRL)  ppims_decode = RK_CTRL;
            if (off == OFF_RXER)  ppims_decode = RK_RXER;
        end
    endfunction

    function automatic logic [2:0] ppims_port_idx(input logic [ADDR_W-1:0] a);
        logic [3:0] n;
        n = a[17:14] - PORT_FIRST;
        ppims_port_idx = n[2:0];
    endfunction

    function automatic logic [15:0] ppims_merge(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0]  strb,
                                                input logic [15:0] wmask);
        logic [15:0] bm;
        bm = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        ppims_merge = (old_v & ~bm) | (new_v & bm);
    endfunction

endpackage

//--- ppims_cnt_if.sv
// carrier between the register group and a per-port error frame counter.
// assumes one instance per port, driven on the register group clock.
`timescale 1ns/1ps
interface ppims_cnt_if;
    logic        inc;
    logic        clr;
    logic [15:0] clr_val;
    logic [15:0] count;
    modport owner (input inc, input clr, input clr_val, output count);
    modport user  (output inc, output clr, output clr_val, input count);
endinterface

//--- ppims_sync.sv
// two-flop synchroniser bank with rising edge detect on the settled value.
// assumes asynchronous inputs; level_out lags the pin by two edges.
`timescale 1ns/1ps
module ppims_sync
    import ppims_pkg::*;
#(
    parameter int WIDTH = SYNC_W
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;
    logic [WIDTH-1:0] prev_q, prev_d;

    // ========================================================
    // next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;

endmodule

//--- ppims_rxer_cnt.sv
// saturating count of received frames with symbol errors, cleared by read.
// assumes clr_val is the value software was shown; only that much is removed.
`timescale 1ns/1ps
module ppims_rxer_cnt
    import ppims_pkg::*;
(
    input  wire logic   clk_in,
    input  wire logic   reset_n_in,
    ppims_cnt_if.owner  cnt
);

    logic [15:0] count_q, count_d;

    // ========================================================
    // count, clear by subtraction so no frame is lost
    always_comb begin
        count_d = count_q;
        if (cnt.clr) begin
            count_d = count_d - cnt.clr_val;
        end
        if (cnt.inc && count_d != CNT_MAX) begin
            count_d = count_d + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    assign cnt.count = count_q;

    // ========================================================
    // checks
    AST_CNT_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cnt.inc && !cnt.clr && count_q != CNT_MAX |=> count_q == $past(count_q) + 16'h0001)
        else $error("error frame counter missed an increment");

    AST_CNT_CLR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cnt.clr && !cnt.inc |=> count_q == $past(count_q) - $past(cnt.clr_val))
        else $error("error frame counter read clear wrong");

endmodule

//--- phy_port_irq_mdix_status_regs.sv
// apb register group for five copper phy ports: event enables and flags,
// crossover selection, jabber counter enable, speed/duplex status, error frames.
// assumes phy-side inputs are asynchronous and apb is on clk_in.
//
// Operation
// - bit 15 enables the jabber flag in bit 7 onto the port request, reset 0.
// - bit 14 enables the receive error flag in bit 6, reset 0.
// - bit 13 enables the page received flag in bit 5, reset 0.
// - bit 12 enables the parallel detect fault flag in bit 4, reset 0.
// - bit 11 enables the link partner acknowledge flag in bit 3, reset 0.
// - bit 10 enables the link down flag in bit 2, reset 0.
// - bit 9 enables the remote fault flag in bit 1, reset 0.
// - bit 8 enables the link up flag in bit 0, reset 0.
// - each flag in bits 7..0 sets on its event, ignores writes and clears once read.
// - with auto crossover off, bit 7 forces mdi when one and mdi-x when zero.
// - bit 6 at one turns automatic crossover off, at zero it runs.
// - control bit 9 runs the jabber counter, reset one.
// - control bits 5, 4 and 3 report 100 mb, 10 mb and full duplex.
// - each port counts frames with symbol errors, read clears the count.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module phy_port_irq_mdix_status_regs
    import ppims_pkg::*;
(
    input  wire logic                            clk_in,
    input  wire logic                            reset_n_in,
    input  wire logic                            psel_in,
    input  wire logic                            penable_in,
    input  wire logic                            pwrite_in,
    input  wire logic [ADDR_W-1:0]               paddr_in,
    input  wire logic [31:0]                     pwdata_in,
    input  wire logic [3:0]                      pstrb_in,
    output logic      [31:0]                     prdata_out,
    output logic                                 pready_out,
    output logic                                 pslverr_out,
    input  wire logic [NUM_PORTS-1:0][EVT_W-1:0] phy_event_in,
    input  wire logic [NUM_PORTS-1:0]            symbol_err_frame_in,
    input  wire logic [NUM_PORTS-1:0]            speed100_in,
    input  wire logic [NUM_PORTS-1:0]            speed10_in,
    input  wire logic [NUM_PORTS-1:0]            full_duplex_in,
    output logic      [NUM_PORTS-1:0]            auto_mdix_en_out,
    output logic      [NUM_PORTS-1:0]            forced_mdi_out,
    output logic      [NUM_PORTS-1:0]            forced_mdix_out,
    output logic      [NUM_PORTS-1:0]            jabber_cnt_en_out,
    output logic      [NUM_PORTS-1:0]            port_irq_out,
    output logic                                 irq_out
);

    // ========================================================
    // synchronised phy inputs
    logic [SYNC_W-1:0] sy_raw;
    logic [SYNC_W-1:0] sy_lvl;
    logic [SYNC_W-1:0] sy_rise;

    always_comb begin
        sy_raw = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            sy_raw[p*SY_PER_PORT +: EVT_W]    = phy_event_in[p];
            sy_raw[p*SY_PER_PORT + SY_SYMERR] = symbol_err_frame_in[p];
            sy_raw[p*SY_PER_PORT + SY_DUP]    = full_duplex_in[p];
            sy_raw[p*SY_PER_PORT + SY_SP10]   = speed10_in[p];
            sy_raw[p*SY_PER_PORT + SY_SP100]  = speed100_in[p];
        end
    end

    ppims_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (sy_raw),
        .level_out  (sy_lvl),
        .rise_out   (sy_rise)
    );

    // ========================================================
    // apb decode
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd_done;
    ppims_reg_t kind;
    logic [2:0] pidx;

    assign setup   = psel_in && !penable_in;
    assign access  = psel_in && penable_in;
    assign wr      = access && pwrite_in;
    assign rd_done = access && !pwrite_in;
    assign kind    = ppims_decode(paddr_in);
    assign pidx    = ppims_port_idx(paddr_in);

    // ========================================================
    // error frame counters
    logic [15:0] cnt_val [NUM_PORTS];
    logic [31:0] prdata_q, prdata_d;
    logic        slverr_q, slverr_d;

    ppims_cnt_if cnt_if [NUM_PORTS] ();

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_cnt
        assign cnt_if[g].inc     = sy_rise[g*SY_PER_PORT + SY_SYMERR];
        assign cnt_if[g].clr     = rd_done && kind == RK_RXER && pidx == 3'(g);
        assign cnt_if[g].clr_val = prdata_q[15:0];
        assign cnt_val[g]        = cnt_if[g].count;
        ppims_rxer_cnt u_cnt (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .cnt        (cnt_if[g].owner)
        );
    end

    // ========================================================
    // register state
    logic [15:0]          evt_q   [NUM_PORTS];
    logic [15:0]          evt_d   [NUM_PORTS];
    logic [15:0]          xover_q [NUM_PORTS];
    logic [15:0]          xover_d [NUM_PORTS];
    logic [15:0]          ctrl_q  [NUM_PORTS];
    logic [15:0]          ctrl_d  [NUM_PORTS];
    logic [NUM_PORTS-1:0] gstat_q, gstat_d;
    logic [NUM_PORTS-1:0] gmask_q, gmask_d;
    logic [NUM_PORTS-1:0] port_irq;
    logic [NUM_PORTS-1:0] auto_q, auto_d;
    logic [NUM_PORTS-1:0] fmdi_q, fmdi_d;
    logic [NUM_PORTS-1:0] fmdix_q, fmdix_d;
    logic [NUM_PORTS-1:0] jab_q, jab_d;

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_irq[p] = |(evt_q[p][EVT_EN_LSB +: EVT_W] & evt_q[p][EVT_FLAG_LSB +: EVT_W]);
        end
    end

    // ========================================================
    // next register values
    always_comb begin
        gmask_d = gmask_q;
        gstat_d = gstat_q;
        if (wr && kind == RK_GMASK && pstrb_in[0]) begin
            gmask_d = pwdata_in[NUM_PORTS-1:0];
        end
        if (wr && kind == RK_GSTAT && pstrb_in[0]) begin
            gstat_d = gstat_d & ~pwdata_in[NUM_PORTS-1:0];
        end
        gstat_d = gstat_d | port_irq;
        for (int p = 0; p < NUM_PORTS; p++) begin
            evt_d[p]   = evt_q[p];
            xover_d[p] = xover_q[p];
            ctrl_d[p]  = ctrl_q[p];
            if (rd_done && kind == RK_EVT && pidx == 3'(p)) begin
                evt_d[p][EVT_FLAG_LSB +: EVT_W] = evt_q[p][EVT_FLAG_LSB +: EVT_W]
                                                & ~prdata_q[EVT_FLAG_LSB +: EVT_W];
            end
            if (wr && pidx == 3'(p)) begin
                unique case (kind)
                    RK_EVT:   evt_d[p]   = ppims_merge(evt_q[p], pwdata_in[15:0],
                                               pstrb_in[1:0], EN_WMASK);
                    RK_XOVER: xover_d[p] = ppims_merge(xover_q[p], pwdata_in[15:0],
                                               pstrb_in[1:0], ALL_WMASK);
                    RK_CTRL:  ctrl_d[p]  = ppims_merge(ctrl_q[p], pwdata_in[15:0],
                                               pstrb_in[1:0], CTRL_WMASK);
                    RK_NONE, RK_RXER, RK_GSTAT, RK_GMASK: ;
                endcase
            end
            evt_d[p][EVT_FLAG_LSB +: EVT_W] = evt_d[p][EVT_FLAG_LSB +: EVT_W]
                                            | sy_rise[p*SY_PER_PORT +: EVT_W];
            auto_d[p]  = !xover_q[p][XOVER_AUTO_OFF];
            fmdi_d[p]  = xover_q[p][XOVER_AUTO_OFF] && xover_q[p][XOVER_MDI_BIT];
            fmdix_d[p] = xover_q[p][XOVER_AUTO_OFF] && !xover_q[p][XOVER_MDI_BIT];
            jab_d[p]   = ctrl_q[p][CTRL_JAB_BIT];
        end
    end

    // ========================================================
    // read data, captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            prdata_d = '0;
            slverr_d = 1'b0;
            unique case (kind)
                RK_EVT:   prdata_d[15:0] = evt_q[pidx];
                RK_XOVER: prdata_d[15:0] = xover_q[pidx];
                RK_CTRL: begin
                    prdata_d[15:0] = ctrl_q[pidx] & CTRL_WMASK;
                    prdata_d[CTRL_SP100_BIT] = sy_lvl[pidx*SY_PER_PORT + SY_SP100];
                    prdata_d[CTRL_SP10_BIT]  = sy_lvl[pidx*SY_PER_PORT + SY_SP10];
                    prdata_d[CTRL_DUP_BIT]   = sy_lvl[pidx*SY_PER_PORT + SY_DUP];
                end
                RK_RXER:  prdata_d[15:0] = cnt_val[pidx];
                RK_GSTAT: prdata_d[NUM_PORTS-1:0] = gstat_q;
                RK_GMASK: prdata_d[NUM_PORTS-1:0] = gmask_q;
                RK_NONE:  slverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                evt_q[p]   <= EVT_RST;
                xover_q[p] <= XOVER_RST;
                ctrl_q[p]  <= CTRL_RST;
            end
            gstat_q  <= '0;
            gmask_q  <= '0;
            auto_q   <= '1;
            fmdi_q   <= '0;
            fmdix_q  <= '0;
            jab_q    <= '1;
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                evt_q[p]   <= evt_d[p];
                xover_q[p] <= xover_d[p];
                ctrl_q[p]  <= ctrl_d[p];
            end
            gstat_q  <= gstat_d;
            gmask_q  <= gmask_d;
            auto_q   <= auto_d;
            fmdi_q   <= fmdi_d;
            fmdix_q  <= fmdix_d;
            jab_q    <= jab_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ========================================================
    // outputs
    assign prdata_out        = prdata_q;
    assign pready_out        = 1'b1;
    assign pslverr_out       = slverr_q && access;
    assign auto_mdix_en_out  = auto_q;
    assign forced_mdi_out    = fmdi_q;
    assign forced_mdix_out   = fmdix_q;
    assign jabber_cnt_en_out = jab_q;
    assign port_irq_out      = port_irq;
    assign irq_out           = |(gstat_q & gmask_q);

    // ========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
        sequence s_evt_read;
            setup && kind == RK_EVT && pidx == 3'(g) ##1 rd_done;
        endsequence

        AST_FLAG_SET: assert property (
            (evt_q[g][7:0] & $past(sy_rise[g*SY_PER_PORT +: EVT_W]))
                == $past(sy_rise[g*SY_PER_PORT +: EVT_W]))
            else $error("event flag not set by its event");

        AST_FLAG_RC: assert property (s_evt_read |=>
            (evt_q[g][7:0] & $past(prdata_q[7:0])
                & ~$past(sy_rise[g*SY_PER_PORT +: EVT_W])) == 8'h00)
            else $error("read flag not cleared");

        AST_EN_WR: assert property (
            wr && kind == RK_EVT && pidx == 3'(g) && pstrb_in[1]
                |=> evt_q[g][15:8] == $past(pwdata_in[15:8]))
            else $error("event enables not written");

        AST_NO_EN: assert property (
            evt_q[g][15:8] == 8'h00 |-> !port_irq_out[g])
            else $error("port request without enable");

        AST_IRQ_PATH: assert property (
            (evt_q[g][15:8] & evt_q[g][7:0]) != 8'h00 && gmask_q[g]
                && !(wr && kind == RK_GMASK) |=> irq_out)
            else $error("enabled flag did not raise interrupt");

        AST_FORCE: assert property (xover_q[g][XOVER_AUTO_OFF] |=>
            !auto_mdix_en_out[g] && forced_mdi_out[g] == $past(xover_q[g][XOVER_MDI_BIT])
                && forced_mdix_out[g] == !$past(xover_q[g][XOVER_MDI_BIT]))
            else $error("manual orientation not forced");

        AST_AUTO: assert property (!xover_q[g][XOVER_AUTO_OFF] |=>
            auto_mdix_en_out[g] && !forced_mdi_out[g] && !forced_mdix_out[g])
            else $error("auto crossover not running");

        AST_JAB: assert property (
            ctrl_q[g][CTRL_JAB_BIT] |=> jabber_cnt_en_out[g])
            else $error("jabber counter not enabled");

        AST_SPEED: assert property (
            setup && kind == RK_CTRL && pidx == 3'(g) |=>
                prdata_q[CTRL_SP100_BIT] == $past(sy_lvl[g*SY_PER_PORT + SY_SP100])
                && prdata_q[CTRL_DUP_BIT] == $past(sy_lvl[g*SY_PER_PORT + SY_DUP]))
            else $error("speed or duplex status wrong");
    end

    AST_UNMAPPED: assert property (
        setup && kind == RK_NONE ##1 access |-> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped address not refused");

endmodule

//--- phy_port_irq_mdix_status_regs_test.sv
// testbench for the per-port phy event, crossover and status registers.
// assumes apb answers within 20 cycles and phy inputs seen three edges after a change.
`timescale 1ns/1ps
module phy_port_irq_mdix_status_regs_test;
    import ppims_pkg::*;
    logic                            clk_in = 0;
    logic                            reset_n_in = 0;
    logic                            psel_in = 0;
    logic                            penable_in = 0;
    logic                            pwrite_in = 0;
    logic [ADDR_W-1:0]               paddr_in = '0;
    logic [31:0]                     pwdata_in = '0;
    logic [3:0]                      pstrb_in = 4'hF;
    logic [31:0]                     prdata_out;
    logic [31:0]                     rd;
    logic                            pready_out;
    logic                            pslverr_out;
    logic                            er;
    logic                            irq_out;
    logic [NUM_PORTS-1:0][EVT_W-1:0] phy_event_in = '0;
    logic [NUM_PORTS-1:0]            symbol_err_frame_in = '0;
    logic [NUM_PORTS-1:0]            speed100_in = '0;
    logic [NUM_PORTS-1:0]            speed10_in = '0;
    logic [NUM_PORTS-1:0]            full_duplex_in = '0;
    logic [NUM_PORTS-1:0]            auto_mdix_en_out;
    logic [NUM_PORTS-1:0]            forced_mdi_out;
    logic [NUM_PORTS-1:0]            forced_mdix_out;
    logic [NUM_PORTS-1:0]            jabber_cnt_en_out;
    logic [NUM_PORTS-1:0]            port_irq_out;
    int                              fail_count = 0;
    int                              n_checks = 0;

    phy_port_irq_mdix_status_regs uut (.clk_in, .reset_n_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
        .pslverr_out, .phy_event_in, .symbol_err_frame_in, .speed100_in, .speed10_in,
        .full_duplex_in, .auto_mdix_en_out, .forced_mdi_out, .forced_mdix_out,
        .jabber_cnt_en_out, .port_irq_out, .irq_out);

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    // ==================================================
    // shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic apb(input logic w, input int p, input logic [11:0] i, input int d);
        int k;
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= {p[3:0], i, 2'b00};
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 20);
        if (k >= 20) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic pulse(input int p, input int b);
        phy_event_in[p][b] <= 1;
        cyc(2);
        phy_event_in[p][b] <= 0;
        cyc(4);
    endtask

    // ==================================================
    // scenarios
    task automatic t_reset;
        apb(0, 1, OFF_EVT, 0);
        chk(rd, 0);
        apb(0, 1, OFF_XOVER, 0);
        chk(rd, 0);
        apb(0, 1, OFF_CTRL, 0);
        chk(rd, 32'h0000_0300);
        chk(auto_mdix_en_out, 32'h0000_001F);
        chk(jabber_cnt_en_out, 32'h0000_001F);
    endtask

    task automatic t_events;
        int en;
        for (int b = 0; b < 8; b++) begin
            en = 32'hFF00 & ~(32'h100 << b);
            apb(1, b % 5 + 1, OFF_EVT, en | 32'h00FF);
            pulse(b % 5, b);
            chk(port_irq_out, 0);
            apb(0, b % 5 + 1, OFF_EVT, 0);
            chk(rd, en | (1 << b));
            apb(0, b % 5 + 1, OFF_EVT, 0);
            chk(rd, en);
            apb(1, b % 5 + 1, OFF_EVT, 32'h100 << b);
            pulse(b % 5, b);
            chk(port_irq_out, 1 << (b % 5));
            apb(0, b % 5 + 1, OFF_EVT, 0);
            chk(port_irq_out, 0);
        end
    endtask

    task automatic t_global;
        apb(1, 0, OFF_GSTAT, 32'h1F);
        apb(1, 0, OFF_GMASK, 1);
        chk(irq_out, 0);
        apb(1, 1, OFF_EVT, 32'h0100);
        pulse(0, 0);
        chk(irq_out, 1);
        apb(0, 1, OFF_EVT, 0);
        apb(1, 0, OFF_GSTAT, 32'h1F);
        chk(irq_out, 0);
        apb(1, 0, OFF_GMASK, 0);
    endtask

    task automatic t_xover;
        apb(1, 2, OFF_XOVER, 32'h0040);
        chk({auto_mdix_en_out, forced_mdi_out, forced_mdix_out}, 32'h7402);
        apb(1, 2, OFF_XOVER, 32'h00C0);
        chk({auto_mdix_en_out, forced_mdi_out, forced_mdix_out}, 32'h7440);
        apb(1, 2, OFF_XOVER, 32'h0080);
        chk({auto_mdix_en_out, forced_mdi_out, forced_mdix_out}, 32'h7C00);
        apb(0, 2, OFF_XOVER, 0);
        chk(rd, 32'h0080);
    endtask

    task automatic t_ctrl;
        speed100_in[2] <= 1;
        full_duplex_in[2] <= 1;
        apb(1, 3, OFF_CTRL, 32'h0038);
        chk(jabber_cnt_en_out, 32'h1B);
        apb(0, 3, OFF_CTRL, 0);
        chk(rd, 32'h0028);
        speed100_in[2] <= 0;
        speed10_in[2] <= 1;
        full_duplex_in[2] <= 0;
        cyc(4);
        apb(0, 3, OFF_CTRL, 0);
        chk(rd, 32'h0010);
    endtask

    task automatic t_cnt;
        repeat (2) begin
            symbol_err_frame_in[4] <= 1;
            cyc(2);
            symbol_err_frame_in[4] <= 0;
            cyc(3);
        end
        apb(0, 5, OFF_RXER, 0);
        chk(rd, 2);
        apb(0, 5, OFF_RXER, 0);
        chk(rd, 0);
        apb(0, 6, OFF_EVT, 0);
        chk(er, 1);
        chk(rd, 0);
    endtask

    // ==================================================
    // main sequence
    initial begin
        cyc(3);
        reset_n_in <= 1;
        @(posedge clk_in);
        t_reset();
        t_events();
        t_global();
        t_xover();
        t_ctrl();
        t_cnt();
        wrap_up();
    end
endmodule
